// file: ccd_map.vh
// Constant map for the counter channel daisy-chain interrupt block.
`ifndef CCD_MAP_VH
`define CCD_MAP_VH
`define CCD_OP_PREFIX   8'hED
`define CCD_OP_RETURN   8'h4D
`define CCD_CNT_W       8
`define CCD_CNT_ONE     8'h01
`define CCD_CNT_ZERO    8'h00
`define CCD_VEC_BASE_W  5
`define CCD_NCH         4
`endif

// file: ccd_counter_daisy.v
// Four-channel down-counter with daisy-chained vectored interrupt logic.
`timescale 1ns/100ps
`include "ccd_map.vh"
//
// Overview of operation
// - Trigger edge decrements counter, clock synchronised.
// - Late trigger edge counts one cycle later.
// - Zero-count pulse follows clock edge reaching zero.
// - Channel 0 highest priority, channel 3 lowest.
// - Service blocks lower channels, allows higher ones.
// - Enabled channel requests interrupt on each zero outside cycle-one.
// - Acknowledge answers only with chain input high.
// - Vector: five programmed bits, channel, zero.
// - Requests frozen while cycle-one is active.
// - Vector driven when I/O request falls.
// - Snoop fetches for two-byte return code.
// - Prefix byte arms return-code check for the next fetch.
// - Return byte releases serviced channel, chain reopens.
// - Chain output high only if input high, idle.
// - I/O request with cycle-one means acknowledge.
// - Open-drain request low while enabled zero pending and not blocked by service.
// - Reset stops counts, clears pending and service, outputs idle.
module ccd_counter_daisy #(
  parameter NCH   = `CCD_NCH,
  parameter CNT_W = `CCD_CNT_W
) (
  // Clock and reset
  input  wire              sys_clk_i,
  input  wire              rst_n_i,
  // Channel configuration and counting
  input  wire [NCH-1:0]    ext_count_trigger_i,
  input  wire [NCH-1:0]    trig_rising_i,
  input  wire [NCH-1:0]    count_run_i,
  input  wire [NCH-1:0]    irq_enable_i,
  input  wire [NCH-1:0]    load_i,
  input  wire [CNT_W-1:0]  time_const_i,
  input  wire [4:0]        vector_base_i,
  output reg  [NCH-1:0]    zero_count_pulse_o,
  // CPU bus
  input  wire              cpu_cycle_one_n_i,
  input  wire              io_request_n_i,
  input  wire              read_n_i,
  input  wire [7:0]        data_i,
  output reg  [7:0]        data_o,
  output reg               data_oe_o,
  // Interrupt and daisy chain
  output wire              int_n_o,
  output wire              int_oe_o,
  input  wire              chain_enable_in_i,
  output wire              chain_enable_out_o
);

  reg rst_s1;
  reg rst_s2;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_n = rst_s2;

  // Two-flop synchronisers for asynchronous pins.
  // No logic sits in front of the first flop; the trigger polarity is applied
  // only after the second flop, so a metastable first stage is never decoded.
  reg [NCH-1:0] trg_s1;
  reg [NCH-1:0] trg_s2;
  reg [NCH-1:0] trg_s3;
  reg [7:0]     data_s1;
  reg [7:0]     data_s2;
  reg [2:0]     m1_s;
  reg [2:0]     io_request_n_s;
  reg [1:0]     rd_s;
  reg [1:0]     iei_s;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trg_s1 <= {NCH{1'b0}};
      trg_s2 <= {NCH{1'b0}};
      trg_s3 <= {NCH{1'b0}};
      m1_s   <= 3'h7;
      io_request_n_s <= 3'h7;
      rd_s   <= 2'h3;
      iei_s  <= 2'h0;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
    end else begin
      trg_s1 <= ext_count_trigger_i;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
      m1_s   <= {m1_s[1:0], cpu_cycle_one_n_i};
      io_request_n_s <= {io_request_n_s[1:0], io_request_n_i};
      rd_s   <= {rd_s[0], read_n_i};
      iei_s  <= {iei_s[0], chain_enable_in_i};
      data_s1 <= data_i;
      data_s2 <= data_s1;
    end
  end

  // The opcode bus must still hold the fetched byte at the first clock after the
  // cycle-one strobe returns high, because the byte is taken from the
  // synchronised copy at the same edge on which the strobe end is seen.

  wire m1_act   = ~m1_s[1];
  wire io_request_n_act = ~io_request_n_s[1];
  wire rd_act   = ~rd_s[1];
  wire chain_enable_in      = iei_s[1];
  // Acknowledge starts on falling edge of synced I/O request with cycle-one.
  wire ack_go   = m1_act & io_request_n_act & io_request_n_s[2] & ~rd_act;
  // Fetch byte captured when cycle-one ends with I/O request inactive.
  wire fetch_go = ~m1_s[2] & m1_s[1] & ~io_request_n_act;

  // Channel counters.
  reg  [CNT_W-1:0] cnt [0:NCH-1];
  reg  [NCH-1:0]   pend;
  reg  [NCH-1:0]   serv;
  wire [NCH-1:0]   hit;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // A late edge is simply seen one synchroniser cycle later.
      // Levels are turned so that the active edge always reads as a rise.
      wire lvl_now   = trg_s2[g] ^ ~trig_rising_i[g];
      wire lvl_prev  = trg_s3[g] ^ ~trig_rising_i[g];
      wire edge_seen = lvl_now & ~lvl_prev;
      assign hit[g] = count_run_i[g] & edge_seen & (cnt[g] == `CCD_CNT_ONE);
      always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          cnt[g]                <= `CCD_CNT_ZERO;
          zero_count_pulse_o[g] <= 1'b0;
        end else begin
          zero_count_pulse_o[g] <= hit[g];
          if (load_i[g]) begin
            cnt[g] <= time_const_i;
          end else if (count_run_i[g] && edge_seen) begin
            cnt[g] <= hit[g] ? time_const_i : cnt[g] - `CCD_CNT_ONE;
          end
        end
      end
    end
  endgenerate

  // Priority: lowest index wins among a mask.
  function [NCH-1:0] ccd_first;
    input [NCH-1:0] v;
    integer k;
    reg found;
    begin
      ccd_first = {NCH{1'b0}};
      found = 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        if (v[k] && !found) begin
          ccd_first[k] = 1'b1;
          found = 1'b1;
        end
      end
    end
  endfunction

  function [1:0] ccd_enc;
    input [NCH-1:0] oh;
    integer k;
    begin
      ccd_enc = 2'h0;
      for (k = 0; k < NCH; k = k + 1) begin
        if (oh[k]) ccd_enc = k[1:0];
      end
    end
  endfunction

  // Channels above the highest serviced one may still interrupt.
  // The serviced one-hot minus one marks every channel of higher priority;
  // with nothing in service the inversion opens all channels.
  // A request of lower priority stays pending and reappears once released.
  wire [NCH-1:0] serv_top = ccd_first(serv);
  wire [NCH-1:0] allow    = serv_top - {{(NCH-1){1'b0}}, |serv} ^ {NCH{~|serv}};
  wire [NCH-1:0] win      = ccd_first(pend & allow);
  wire           any_win  = |win;

  reg prefix_seen;
  // The return code releases only the highest-priority channel in service,
  // which is the one whose service routine ends first when nested.
  wire ret_go = fetch_go & prefix_seen & (data_s2 == `CCD_OP_RETURN);
  wire [NCH-1:0] rel = ret_go ? serv_top : {NCH{1'b0}};
  wire [NCH-1:0] grant = (ack_go && chain_enable_in && any_win) ? win : {NCH{1'b0}};

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend        <= {NCH{1'b0}};
      serv        <= {NCH{1'b0}};
      prefix_seen <= 1'b0;
      data_o      <= 8'h00;
      data_oe_o   <= 1'b0;
    end else begin
      // Request status freezes during cycle-one; hits are then dropped.
      if (!m1_act) begin
        pend <= (pend | (hit & irq_enable_i)) & irq_enable_i;
      end else begin
        pend <= pend & ~grant;
      end
      serv <= (serv | grant) & ~rel;
      if (fetch_go) begin
        prefix_seen <= (data_s2 == `CCD_OP_PREFIX);
      end
      if (grant != {NCH{1'b0}}) begin
        data_o    <= {vector_base_i, ccd_enc(grant), 1'b0};
        data_oe_o <= 1'b1;
      end else if (!io_request_n_act) begin
        data_oe_o <= 1'b0;
      end
    end
  end

  // The request line is open drain: the pin value is always low and only the
  // enable decides whether this block pulls the shared line down.
  assign int_oe_o           = |(pend & allow);
  assign int_n_o            = 1'b0;
  assign chain_enable_out_o = chain_enable_in_i & ~|serv;
endmodule

// file: ccd_cpu_model.sv
// Bus master model that acknowledges interrupts and fetches opcodes.
`timescale 1ns/100ps
module ccd_cpu_model (
  input  wire        sys_clk_i,
  output logic       cpu_cycle_one_n_i = 1,
  output logic       io_request_n_i = 1,
  output logic       read_n_i = 1,
  output logic [7:0] data_i = 8'hFF
);
  task automatic ack();
    @(negedge sys_clk_i);
    cpu_cycle_one_n_i = 0;
    repeat (2) @(negedge sys_clk_i);
    io_request_n_i = 0;
    repeat (5) @(negedge sys_clk_i);
    cpu_cycle_one_n_i = 1;
    io_request_n_i = 1;
    repeat (3) @(negedge sys_clk_i);
  endtask
  // The byte stands past the synchronised end of the fetch, then turns over.
  task automatic fetch(input logic [7:0] op);
    @(negedge sys_clk_i);
    cpu_cycle_one_n_i = 0;
    read_n_i = 0;
    data_i = op;
    repeat (3) @(negedge sys_clk_i);
    cpu_cycle_one_n_i = 1;
    read_n_i = 1;
    repeat (4) @(negedge sys_clk_i);
    data_i = ~op;
  endtask
endmodule

// file: ccd_counter_daisy_asserts.sv
// Assertion checker for the counter daisy-chain block.
`timescale 1ns/100ps
module ccd_counter_daisy_asserts #(parameter NCH = 4) (
  input wire           sys_clk_i,
  input wire           rst_n_i,
  input wire [NCH-1:0] irq_enable_i,
  input wire [4:0]     vector_base_i,
  input wire [NCH-1:0] zero_count_pulse_o,
  input wire           cpu_cycle_one_n_i,
  input wire           io_request_n_i,
  input wire           read_n_i,
  input wire [7:0]     data_o,
  input wire           data_oe_o,
  input wire           int_n_o,
  input wire           int_oe_o,
  input wire           chain_enable_in_i,
  input wire           chain_enable_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_chain_out_gate: assert property (chain_enable_out_o |-> chain_enable_in_i)
    else $error("chain out high while chain in low");
  a_zero_pulse_short: assert property ((zero_count_pulse_o != 0) |=>
    (zero_count_pulse_o & $past(zero_count_pulse_o)) == 0) else $error("zero pulse too long");
  a_irq_on_zero: assert property ((zero_count_pulse_o & irq_enable_i) != 0 |->
    ##[0:2] int_oe_o) else $error("no request after zero");
  a_int_pin_low: assert property (int_oe_o |-> !int_n_o)
    else $error("request line not low");
  a_vector_shape: assert property (data_oe_o |-> data_o[0] == 1'b0 &&
    data_o[7:3] == vector_base_i) else $error("bad vector");
  a_ack_chain_gate: assert property ($rose(data_oe_o) |-> $past(chain_enable_in_i))
    else $error("vector with chain in low");
  a_ack_strobes: assert property ($rose(data_oe_o) |-> !cpu_cycle_one_n_i && read_n_i)
    else $error("vector outside acknowledge");
  a_vector_stands: assert property (data_oe_o && !io_request_n_i |=> data_oe_o)
    else $error("vector dropped early");
  a_serve_closes: assert property ($rose(data_oe_o) |=> !chain_enable_out_o [*2])
    else $error("chain open while served");
  c_ack: cover property ($rose(data_oe_o));
  c_zero: cover property (zero_count_pulse_o != 0);
  c_reopen: cover property ($rose(chain_enable_out_o));
endmodule
bind ccd_counter_daisy ccd_counter_daisy_asserts #(.NCH(NCH)) ccd_counter_daisy_asserts_inst (.*);

// file: testbench.sv
// Self-checking bench for the counter daisy-chain block.
`timescale 1ns/100ps
module testbench;
  logic       sys_clk_i = 0, rst_n_i = 0, chain_enable_in_i = 1;
  logic [3:0] ext_count_trigger_i = 0, load_i = 0, zs = 0, m;
  logic [3:0] trig_rising_i = 4'hF, count_run_i = 4'hF, irq_enable_i = 4'hF;
  logic [7:0] time_const_i = 8'h02;
  logic [4:0] vector_base_i = 5'h00;
  wire  [3:0] zero_count_pulse_o;
  wire  [7:0] data_i, data_o;
  wire        cpu_cycle_one_n_i, io_request_n_i, read_n_i;
  wire        data_oe_o, int_n_o, int_oe_o, chain_enable_out_o;
  int         err_total = 0, total_checks = 0, seed = 32'h75e4;
  logic [7:0] eq[$];
  always #20 sys_clk_i = ~sys_clk_i;
  ccd_counter_daisy ccd_counter_daisy_inst (.*);
  ccd_cpu_model ccd_cpu_model_inst (.*);
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) zs <= zs | zero_count_pulse_o;
  always @(posedge data_oe_o) begin
    #1 chk("vector", eq.size() ? eq.pop_front() : 8'hXX, data_o);
  end
  initial begin
    #400000 err_total++;
    print_verdict();
  end
  initial begin
    repeat (6) @(negedge sys_clk_i);
    chk("idle", 8'h01, {zero_count_pulse_o, data_oe_o, int_oe_o, 1'b0, chain_enable_out_o});
    rst_n_i = 1;
    repeat (4) @(negedge sys_clk_i);
    for (int r = 0; r < 4; r++) begin
      m = 4'($random(seed)) | 4'(1 << r);
      vector_base_i = 5'($random(seed));
      zs = 0;
      load_i = 4'hF;
      @(negedge sys_clk_i) load_i = 0;
      repeat (4) begin
        ext_count_trigger_i = ext_count_trigger_i ^ m;
        repeat (3) @(negedge sys_clk_i);
      end
      repeat (3) @(negedge sys_clk_i);
      chk("zero", {4'h0, m}, {4'h0, zs});
      chk("irq", 8'h01, {7'h0, int_oe_o});
      if (r == 0) begin
        chain_enable_in_i = 0;
        ccd_cpu_model_inst.ack();
        chk("chain", 8'h00, {7'h0, chain_enable_out_o});
        chain_enable_in_i = 1;
      end
      for (int c = 0; c < 4; c++) if (m[c]) begin
        eq.push_back({vector_base_i, 2'(c), 1'b0});
        ccd_cpu_model_inst.ack();
        chk("served", 8'h00, {7'h0, chain_enable_out_o});
        ccd_cpu_model_inst.fetch(8'hED);
        ccd_cpu_model_inst.fetch(8'h4D);
        chk("release", 8'h01, {7'h0, chain_enable_out_o});
      end
      chk("irq", 8'h00, {7'h0, int_oe_o});
    end
    print_verdict();
  end
endmodule
